// *** hw/ums_line_status.sv ***
/*
 * Modem handshake outputs, line status register, transmit and receive
 * FIFOs, break detection and interrupt for one UART channel, with an APB
 * slave. Assumes the bit shifter and receiver run on the same clock and
 * that the receive pin is asynchronous.
 */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module ums_line_status #(
    parameter int TX_DEPTH     = 128,
    parameter int RX_DEPTH     = 128,
    parameter int BREAK_CYCLES = ums_pkg::BREAK_CYCLES
) (
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [11:0]           paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output logic                       irq_o,
    output logic                       request_to_send_out_n_o,
    output logic                       terminal_ready_out_n_o,
    output logic      [7:0]            tx_byte_o,
    output logic                       tx_start_o,
    input  wire logic                  tx_done_i,
    input  wire logic                  rx_i,
    input  wire logic                  rx_push_i,
    input  wire ums_pkg::ums_rx_char_t rx_char_i
);

    localparam int TXW = $clog2(TX_DEPTH);
    localparam int RXW = $clog2(RX_DEPTH);
    localparam int BCW = $clog2(BREAK_CYCLES + 1);
    localparam int EV_W = ums_pkg::EV_WIDTH;

    // Pointer wrap relies on power-of-two depths.
    if (TX_DEPTH < 2 || (TX_DEPTH & (TX_DEPTH - 1)) != 0 ||
        RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0 ||
        BREAK_CYCLES < 1)
    begin : g_bad_param
        $error("ums_line_status: unsupported parameter value");
    end

    // Address match, used for every register decode.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    // ========================================================================
    // State.
    logic [7:0]           modem_control_reg;
    logic                 fifo_en;
    logic [2:0]           int_stat;
    logic [2:0]           int_en;
    logic                 brk_flag;
    logic [7:0]           tx_mem [TX_DEPTH];
    logic [TXW-1:0]       tx_wr;
    logic [TXW-1:0]       tx_rd;
    logic [TXW:0]         tx_cnt;
    logic                 shift_full;
    ums_pkg::ums_rx_char_t rx_mem [RX_DEPTH];
    logic [RXW-1:0]       rx_wr;
    logic [RXW-1:0]       rx_rd;
    logic [RXW:0]         rx_cnt;
    logic [RXW:0]         err_cnt;
    logic                 rx_meta;
    logic                 rx_sync;
    logic [BCW-1:0]       low_cnt;
    logic                 brk_seen;

    logic [7:0]           next_modem_control_reg;
    logic                 next_fifo_en;
    logic [2:0]           next_int_stat;
    logic [2:0]           next_int_en;
    logic                 next_brk_flag;
    logic [TXW-1:0]       next_tx_wr;
    logic [TXW-1:0]       next_tx_rd;
    logic [TXW:0]         next_tx_cnt;
    logic                 next_shift_full;
    logic [RXW-1:0]       next_rx_wr;
    logic [RXW-1:0]       next_rx_rd;
    logic [RXW:0]         next_rx_cnt;
    logic [RXW:0]         next_err_cnt;
    logic [BCW-1:0]       next_low_cnt;
    logic                 next_brk_seen;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic                 next_irq;
    logic [7:0]           next_tx_byte;
    logic                 next_tx_start;

    // Combinational helpers.
    logic                 access;
    logic                 wr_en;
    logic                 rd_en;
    logic                 mapped;
    logic                 tx_push;
    logic                 tx_pop;
    logic                 rx_push;
    logic                 rx_pop;
    logic                 flush;
    logic                 brk_event;
    logic [TXW:0]         tx_limit;
    logic [RXW:0]         rx_limit;
    ums_pkg::ums_rx_char_t push_char;
    ums_pkg::ums_rx_char_t head;
    logic                 push_err;
    logic                 pop_err;
    logic [7:0]           line_status_reg;
    logic [2:0]           events;

    // ========================================================================
    // Break detection on the synchronised receive line.
    always_comb
    begin
        next_low_cnt  = low_cnt;
        next_brk_seen = brk_seen;
        brk_event     = 1'b0;
        if (rx_sync)
        begin
            next_low_cnt  = '0;
            next_brk_seen = 1'b0;
        end
        else if (!brk_seen)
        begin
            if (low_cnt == BCW'(BREAK_CYCLES - 1))
            begin
                // Held low a whole frame: flag once until the line idles.
                brk_event     = 1'b1;
                next_brk_seen = 1'b1;
                next_low_cnt  = '0;
            end
            else
            begin
                next_low_cnt = low_cnt + 1'b1;
            end
        end
    end

    // ========================================================================
    // Bus decode, FIFO movement and status.
    always_comb
    begin
        access   = psel_i && penable_i && !pready_o;
        wr_en    = access && pwrite_i;
        rd_en    = access && !pwrite_i;
        mapped   = hit(paddr_i, ums_pkg::OFF_DATA) ||
                   hit(paddr_i, ums_pkg::OFF_FIFO_CTRL) ||
                   hit(paddr_i, ums_pkg::OFF_MODEM) ||
                   hit(paddr_i, ums_pkg::OFF_LINE) ||
                   hit(paddr_i, ums_pkg::OFF_INT_STAT) ||
                   hit(paddr_i, ums_pkg::OFF_INT_CLR) ||
                   hit(paddr_i, ums_pkg::OFF_INT_EN);
        // Non-FIFO operation behaves as a single-entry holding register.
        tx_limit = fifo_en ? (TXW+1)'(TX_DEPTH) : (TXW+1)'(1);
        rx_limit = fifo_en ? (RXW+1)'(RX_DEPTH) : (RXW+1)'(1);
        flush    = wr_en && hit(paddr_i, ums_pkg::OFF_FIFO_CTRL) &&
                   (pwdata_i[ums_pkg::FC_ENABLE_BIT] != fifo_en);

        tx_push  = wr_en && hit(paddr_i, ums_pkg::OFF_DATA) &&
                   (tx_cnt < tx_limit);
        tx_pop   = !shift_full && (tx_cnt != '0);

        // A detected break replaces whatever the receiver offers.
        push_char = rx_char_i;
        if (brk_event)
        begin
            push_char = '{brk: 1'b1, framing_err: 1'b0,
                          parity_err: 1'b0, data: 8'h00};
        end
        rx_push  = (brk_event || rx_push_i) && (rx_cnt < rx_limit);
        rx_pop   = rd_en && hit(paddr_i, ums_pkg::OFF_DATA) &&
                   (rx_cnt != '0);
        head     = rx_mem[rx_rd];
        push_err = push_char.brk || push_char.framing_err ||
                   push_char.parity_err;
        pop_err  = head.brk || head.framing_err || head.parity_err;

        line_status_reg = 8'h00;
        line_status_reg[ums_pkg::LS_FERR_BIT]   = (err_cnt != '0);
        line_status_reg[ums_pkg::LS_TEMT_BIT]   =
            (tx_cnt == '0) && !shift_full;
        line_status_reg[ums_pkg::LS_THRE_BIT]   = (tx_cnt == '0);
        line_status_reg[ums_pkg::LS_BREAK_BIT]  = brk_flag;
        line_status_reg[ums_pkg::LS_FRAME_BIT]  =
            (rx_cnt != '0) && head.framing_err;
        line_status_reg[ums_pkg::LS_PARITY_BIT] =
            (rx_cnt != '0) && head.parity_err;
        line_status_reg[ums_pkg::LS_READY_BIT]  = (rx_cnt != '0);

        events = '0;
        events[ums_pkg::EV_THRE_BIT]  = tx_pop && (tx_cnt == (TXW+1)'(1));
        events[ums_pkg::EV_BREAK_BIT] = brk_event;
        events[ums_pkg::EV_RXERR_BIT] = rx_push && push_err;
    end

    // ========================================================================
    // Next register values.
    always_comb
    begin
        next_modem_control_reg = modem_control_reg;
        next_fifo_en = fifo_en;
        next_int_en  = int_en;
        next_int_stat = int_stat;
        next_brk_flag = brk_flag;
        next_tx_wr = tx_wr;
        next_tx_rd = tx_rd;
        next_tx_cnt = tx_cnt;
        next_shift_full = shift_full;
        next_rx_wr = rx_wr;
        next_rx_rd = rx_rd;
        next_rx_cnt = rx_cnt;
        next_err_cnt = err_cnt;
        next_tx_byte = tx_byte_o;
        next_tx_start = 1'b0;
        next_pready = access;
        next_pslverr = access && !mapped;
        next_prdata = 32'h0000_0000;

        if (wr_en && hit(paddr_i, ums_pkg::OFF_MODEM))
        begin
            next_modem_control_reg = pwdata_i[7:0];
        end
        if (wr_en && hit(paddr_i, ums_pkg::OFF_FIFO_CTRL))
        begin
            next_fifo_en = pwdata_i[ums_pkg::FC_ENABLE_BIT];
        end
        if (wr_en && hit(paddr_i, ums_pkg::OFF_INT_EN))
        begin
            next_int_en = pwdata_i[EV_W-1:0];
        end
        // Clearing write first, so a same-cycle event still sets the bit.
        if (wr_en && hit(paddr_i, ums_pkg::OFF_INT_CLR))
        begin
            next_int_stat = int_stat & ~pwdata_i[EV_W-1:0];
        end
        next_int_stat = next_int_stat | events;
        // Reading line status clears break; a new break wins.
        if (rd_en && hit(paddr_i, ums_pkg::OFF_LINE))
        begin
            next_brk_flag = 1'b0;
        end
        if (brk_event)
        begin
            next_brk_flag = 1'b1;
        end

        // Transmit path: a write fills, the idle shifter drains.
        if (tx_push)
        begin
            next_tx_wr = tx_wr + 1'b1;
        end
        if (tx_pop)
        begin
            next_tx_rd      = tx_rd + 1'b1;
            next_shift_full = 1'b1;
            next_tx_byte    = tx_mem[tx_rd];
            next_tx_start   = 1'b1;
        end
        else if (tx_done_i)
        begin
            next_shift_full = 1'b0;
        end
        next_tx_cnt = tx_cnt + (TXW+1)'(tx_push) - (TXW+1)'(tx_pop);

        // Receive path with a running count of flagged characters.
        if (rx_push)
        begin
            next_rx_wr = rx_wr + 1'b1;
        end
        if (rx_pop)
        begin
            next_rx_rd  = rx_rd + 1'b1;
        end
        next_rx_cnt  = rx_cnt + (RXW+1)'(rx_push) - (RXW+1)'(rx_pop);
        next_err_cnt = err_cnt + (RXW+1)'(rx_push && push_err)
                       - (RXW+1)'(rx_pop && pop_err);

        // Changing mode discards both queues.
        if (flush)
        begin
            next_tx_wr   = '0;
            next_tx_rd   = '0;
            next_tx_cnt  = '0;
            next_rx_wr   = '0;
            next_rx_rd   = '0;
            next_rx_cnt  = '0;
            next_err_cnt = '0;
        end

        if (rd_en)
        begin
            case (1'b1)
                hit(paddr_i, ums_pkg::OFF_DATA):
                    next_prdata = {24'h000000, head.data};
                hit(paddr_i, ums_pkg::OFF_FIFO_CTRL):
                    next_prdata = {31'h00000000, fifo_en};
                hit(paddr_i, ums_pkg::OFF_MODEM):
                    next_prdata = {24'h000000, modem_control_reg};
                hit(paddr_i, ums_pkg::OFF_LINE):
                    next_prdata = {24'h000000, line_status_reg};
                hit(paddr_i, ums_pkg::OFF_INT_STAT):
                    next_prdata = {29'h00000000, int_stat};
                hit(paddr_i, ums_pkg::OFF_INT_EN):
                    next_prdata = {29'h00000000, int_en};
                default:
                    next_prdata = 32'h0000_0000;
            endcase
        end

        // Level interrupt from enabled sticky bits or holding empty.
        next_irq = |(next_int_stat & next_int_en) ||
                   ((next_tx_cnt == '0) &&
                    next_int_en[ums_pkg::EV_THRE_BIT]);
    end

    // ========================================================================
    // Registers.
    always_ff @(posedge clock_i)
    begin
        rx_meta <= rx_i;
        rx_sync <= rx_meta;
        if (tx_push)
        begin
            tx_mem[tx_wr] <= pwdata_i[7:0];
        end
        if (rx_push)
        begin
            rx_mem[rx_wr] <= push_char;
        end
        if (!rstn_i)
        begin
            modem_control_reg       <= ums_pkg::MODEM_RESET;
            fifo_en                 <= ums_pkg::FIFO_CTRL_RESET[0];
            int_en                  <= ums_pkg::INT_EN_RESET;
            int_stat                <= '0;
            brk_flag                <= 1'b0;
            tx_wr                   <= '0;
            tx_rd                   <= '0;
            tx_cnt                  <= '0;
            shift_full              <= 1'b0;
            rx_wr                   <= '0;
            rx_rd                   <= '0;
            rx_cnt                  <= '0;
            err_cnt                 <= '0;
            low_cnt                 <= '0;
            brk_seen                <= 1'b1;
            prdata_o                <= 32'h0000_0000;
            pready_o                <= 1'b0;
            pslverr_o               <= 1'b0;
            irq_o                   <= 1'b0;
            request_to_send_out_n_o <= 1'b1;
            terminal_ready_out_n_o  <= 1'b1;
            tx_byte_o               <= 8'h00;
            tx_start_o              <= 1'b0;
        end
        else
        begin
            modem_control_reg       <= next_modem_control_reg;
            fifo_en                 <= next_fifo_en;
            int_en                  <= next_int_en;
            int_stat                <= next_int_stat;
            brk_flag                <= next_brk_flag;
            tx_wr                   <= next_tx_wr;
            tx_rd                   <= next_tx_rd;
            tx_cnt                  <= next_tx_cnt;
            shift_full              <= next_shift_full;
            rx_wr                   <= next_rx_wr;
            rx_rd                   <= next_rx_rd;
            rx_cnt                  <= next_rx_cnt;
            err_cnt                 <= next_err_cnt;
            low_cnt                 <= next_low_cnt;
            brk_seen                <= next_brk_seen;
            prdata_o                <= next_prdata;
            pready_o                <= next_pready;
            pslverr_o               <= next_pslverr;
            irq_o                   <= next_irq;
            // Set bit drives the pin low; clear holds it high.
            request_to_send_out_n_o <=
                !next_modem_control_reg[ums_pkg::MC_RTS_BIT];
            terminal_ready_out_n_o  <=
                !next_modem_control_reg[ums_pkg::MC_DTR_BIT];
            tx_byte_o               <= next_tx_byte;
            tx_start_o              <= next_tx_start;
        end
    end

endmodule // ums_line_status

// *** hw/ums_pkg.sv ***
/*
 * Shared constants and types for the modem control and line status block.
 * Assumes a single 100 MHz clock domain and a 32-bit APB register bus.
 */
package ums_pkg;

    // ========================================================================
    // Register byte offsets.
    localparam logic [11:0] OFF_DATA      = 12'h000;
    localparam logic [11:0] OFF_FIFO_CTRL = 12'h008;
    localparam logic [11:0] OFF_MODEM     = 12'h010;
    localparam logic [11:0] OFF_LINE      = 12'h014;
    localparam logic [11:0] OFF_INT_STAT  = 12'h020;
    localparam logic [11:0] OFF_INT_CLR   = 12'h024;
    localparam logic [11:0] OFF_INT_EN    = 12'h028;

    // ========================================================================
    // Field positions.
    localparam int MC_DTR_BIT    = 0;
    localparam int MC_RTS_BIT    = 1;
    localparam int FC_ENABLE_BIT = 0;
    localparam int LS_READY_BIT  = 0;
    localparam int LS_PARITY_BIT = 2;
    localparam int LS_FRAME_BIT  = 3;
    localparam int LS_BREAK_BIT  = 4;
    localparam int LS_THRE_BIT   = 5;
    localparam int LS_TEMT_BIT   = 6;
    localparam int LS_FERR_BIT   = 7;
    localparam int EV_THRE_BIT   = 0;
    localparam int EV_BREAK_BIT  = 1;
    localparam int EV_RXERR_BIT  = 2;
    localparam int EV_WIDTH      = 3;

    // ========================================================================
    // Reset values.
    localparam logic [7:0] MODEM_RESET     = 8'h00;
    localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
    localparam logic [2:0] INT_EN_RESET    = 3'h0;

    // ========================================================================
    // Timing: a break is the line held low for one character frame.
    localparam int CLK_PERIOD_NS = 10;
    localparam int BIT_TIME_NS   = 8680;
    localparam int FRAME_BITS    = 10;
    localparam int BREAK_CYCLES  =
        (BIT_TIME_NS * FRAME_BITS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // One received character with its error flags.
    typedef struct packed {
        logic       brk;
        logic       framing_err;
        logic       parity_err;
        logic [7:0] data;
    } ums_rx_char_t;

endpackage : ums_pkg

// *** hw/ums_pkg_tail_unused_guard.sv ***
`timescale 1ns/1ps

// *** tb/ums_shifter_model.sv ***
/* Behavioural transmit shifter that sits beyond the line status block.
   Assumes one clock shared with the block and a delay set by the bench. */
`timescale 1ns/1ps
module ums_shifter_model (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       tx_start_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic [7:0] delay_i,
    output logic            tx_done_o,
    output logic [7:0]      last_byte_o,
    output int              sent_o
);
    // ====================================================================
    // Shifting
    logic [7:0] left;
    logic       busy;

    // A long delay keeps the shifter busy so the queue can fill behind it.
    always_ff @(posedge clock_i)
    begin
        tx_done_o <= 1'b0;
        if (!rstn_i)
        begin
            busy        <= 1'b0;
            left        <= 8'h00;
            sent_o      <= 0;
            last_byte_o <= 8'h00;
        end
        else if (tx_start_i)
        begin
            busy        <= 1'b1;
            left        <= delay_i;
            last_byte_o <= tx_byte_i;
        end
        else if (busy && left == 8'h00)
        begin
            busy      <= 1'b0;
            tx_done_o <= 1'b1;
            sent_o    <= sent_o + 1;
        end
        else if (busy)
            left <= left - 8'h01;
    end
endmodule // ums_shifter_model

// *** tb/ums_line_status_sva.sv ***
/* Port checker for the line status block.
   Assumes it is bound to the block and shares its single clock. */
`timescale 1ns/1ps
module ums_line_status_sva (
    input wire logic        clock_i,
    input wire logic        rstn_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        request_to_send_out_n_o,
    input wire logic        terminal_ready_out_n_o,
    input wire logic [7:0]  tx_byte_o,
    input wire logic        tx_start_o,
    input wire logic        tx_done_i
);
    // ====================================================================
    // Helpers
    logic busy;
    logic taken;
    logic wr_modem;
    logic wr_data;

    // Requests are taken on the first access edge only.
    assign taken    = psel_i && penable_i && !pready_o;
    assign wr_modem = taken && pwrite_i && paddr_i == ums_pkg::OFF_MODEM;
    assign wr_data  = taken && pwrite_i && paddr_i == ums_pkg::OFF_DATA;

    // Shifter occupancy, tracked from the start and done pulses.
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            busy <= 1'b0;
        else if (tx_start_o)
            busy <= 1'b1;
        else if (tx_done_i)
            busy <= 1'b0;
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    rts_drive_a: assert property (wr_modem |-> ##2
        request_to_send_out_n_o == !$past(pwdata_i[1], 2))
        else $error("request to send pin does not follow its bit");
    dtr_drive_a: assert property (wr_modem |-> ##2
        terminal_ready_out_n_o == !$past(pwdata_i[0], 2))
        else $error("terminal ready pin does not follow its bit");
    reset_pins_a: assert property (disable iff (1'b0) !rstn_i |=>
        request_to_send_out_n_o && terminal_ready_out_n_o && !tx_start_o)
        else $error("outputs not at reset level");
    tx_move_a: assert property (wr_data && !busy && !tx_start_o
        && !$past(tx_done_i) |-> ##2 tx_start_o
        && tx_byte_o == $past(pwdata_i[7:0], 2))
        else $error("byte not moved into idle shifter");
    start_idle_a: assert property (tx_start_o |-> !busy)
        else $error("start while shifter busy");
    byte_hold_a: assert property (busy && !tx_start_o |-> $stable(tx_byte_o))
        else $error("shift byte changed while busy");
    apb_answer_a: assert property (taken |=> pready_o ##1 !pready_o)
        else $error("ready not a one cycle answer");
    err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == '0)
        else $error("error answer malformed");

    cover property (wr_modem);
    cover property (tx_start_o ##[1:100] tx_done_i);
    cover property (pslverr_o);
endmodule // ums_line_status_sva

bind ums_line_status ums_line_status_sva u_sva (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .request_to_send_out_n_o(request_to_send_out_n_o),
    .terminal_ready_out_n_o(terminal_ready_out_n_o),
    .tx_byte_o(tx_byte_o), .tx_start_o(tx_start_o), .tx_done_i(tx_done_i)
);

// *** tb/test_ums_line_status.sv ***
/* Self-checking bench for the line status block.
   Assumes the shifter model on the transmit side and the bound checker. */
`timescale 1ns/1ps
module test_ums_line_status;
    // ====================================================================
    // Signals
    logic clock_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, perr, irq, rts_n, dtr_n, tx_start, done;
    logic rx = 1'b1, rx_push = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  tx_byte, last_byte, b;
    ums_pkg::ums_rx_char_t rx_char = '0;
    int err_count = 0, compares = 0, cycles = 0, sent, v, k;

    ums_line_status #(.TX_DEPTH(4), .RX_DEPTH(4), .BREAK_CYCLES(20)) uut (
        .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(perr), .irq_o(irq), .request_to_send_out_n_o(rts_n),
        .terminal_ready_out_n_o(dtr_n), .tx_byte_o(tx_byte),
        .tx_start_o(tx_start), .tx_done_i(done), .rx_i(rx),
        .rx_push_i(rx_push), .rx_char_i(rx_char));
    ums_shifter_model u_shift (.clock_i(clock_i), .rstn_i(rstn_i),
        .tx_start_i(tx_start), .tx_byte_i(tx_byte), .delay_i(8'h3c),
        .tx_done_o(done), .last_byte_o(last_byte), .sent_o(sent));

    // Free-running clock; the cycle ceiling stops a hung run.
    always #5 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    // ====================================================================
    // Tasks
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: value %h, want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch at %0t: pin %b, want %b", $time, g, e);
        end
    endtask
    // Holds the request until ready is seen high, then releases it.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock_i);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd = prdata;
        er = perr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic push(input ums_pkg::ums_rx_char_t c);
        @(posedge clock_i);
        rx_push <= 1'b1;
        rx_char <= c;
        @(posedge clock_i);
        rx_push <= 1'b0;
    endtask
    function automatic logic [31:0] line_status(input logic e, t, h, br, f, p, r);
        line_status = {24'h0, e, t, h, br, f, p, 1'b0, r};
    endfunction

    // ====================================================================
    // Main sequence
    initial
    begin
        v = $urandom(32'h7164ee06);
        repeat (8) @(posedge clock_i);
        rstn_i <= 1'b1;
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 1, 1, 0, 0, 0, 0));
        rd_chk(ums_pkg::OFF_MODEM, 32'h0);
        chk1(rts_n, 1'b1);
        for (k = 0; k < 6; k++)
        begin
            v = (k < 4) ? k : ($urandom & 32'hff);
            apb(1'b1, ums_pkg::OFF_MODEM, v);
            chk1(rts_n, !v[1]);
            chk1(dtr_n, !v[0]);
            rd_chk(ums_pkg::OFF_MODEM, v);
        end
        apb(1'b0, 12'h0fc, 32'h0);
        chk1(er, 1'b1);
        apb(1'b1, ums_pkg::OFF_INT_EN, 32'h1);
        chk1(irq, 1'b1);
        b = 8'($urandom);
        apb(1'b1, ums_pkg::OFF_DATA, {24'h0, b});
        repeat (2) @(posedge clock_i);
        chk(last_byte, b);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 0, 1, 0, 0, 0, 0));
        apb(1'b1, ums_pkg::OFF_INT_CLR, 32'h7);
        apb(1'b1, ums_pkg::OFF_DATA, 32'h000000a5);
        chk1(irq, 1'b0);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 0, 0, 0, 0, 0, 0));
        while (sent < 2) @(negedge clock_i);
        chk(last_byte, 8'ha5);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 1, 1, 0, 0, 0, 0));
        chk1(irq, 1'b1);
        apb(1'b1, ums_pkg::OFF_INT_EN, 32'h0);
        chk1(irq, 1'b0);
        rd_chk(ums_pkg::OFF_INT_STAT, 32'h1);
        apb(1'b1, ums_pkg::OFF_FIFO_CTRL, 32'h1);
        for (k = 0; k < 3; k++)
            apb(1'b1, ums_pkg::OFF_DATA, $urandom & 32'hff);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 0, 0, 0, 0, 0, 0));
        while (sent < 4) @(negedge clock_i);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 0, 1, 0, 0, 0, 0));
        while (sent < 5) @(negedge clock_i);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 1, 1, 0, 0, 0, 0));
        // A flagged character followed by a clean one, for parity then framing.
        for (k = 0; k < 2; k++)
        begin
            b = 8'($urandom);
            push({1'b0, k == 1, k == 0, b});
            push({3'b000, ~b});
            rd_chk(ums_pkg::OFF_LINE, line_status(1, 1, 1, 0, k, !k, 1));
            rd_chk(ums_pkg::OFF_DATA, {24'h0, b});
            rd_chk(ums_pkg::OFF_LINE, line_status(0, 1, 1, 0, 0, 0, 1));
            rd_chk(ums_pkg::OFF_DATA, {24'h0, ~b});
        end
        @(posedge clock_i);
        rx <= 1'b0;
        repeat (30) @(posedge clock_i);
        rx <= 1'b1;
        repeat (4) @(posedge clock_i);
        rd_chk(ums_pkg::OFF_LINE, line_status(1, 1, 1, 1, 0, 0, 1));
        apb(1'b0, ums_pkg::OFF_INT_STAT, 32'h0);
        chk(rd & 32'h2, 32'h2);
        rd_chk(ums_pkg::OFF_DATA, 32'h0);
        rd_chk(ums_pkg::OFF_LINE, line_status(0, 1, 1, 0, 0, 0, 0));
        summarize();
    end
endmodule // test_ums_line_status
